// ---- core/sp_sync_out.sv ----
// Purpose: Sync pulse output on the auxiliary connector, APB controlled
// Assumes: Channel status and ticks come from logic on sys_clk
// Notes:   Aux pin is two-way; it becomes an input under external modulation
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
// Overview of operation
// - Pulses appear only while the sync enable is on; otherwise idle.
// - Source select picks channel one or channel two timing.
// - Basic wave up to 10 MHz gives one 100 ns pulse per period.
// - Unmodulated basic wave above 10 MHz on the source channel gives no pulses.
// - Noise or DC on the source channel gives no pulses.
// - Arbitrary wave gives one 100 ns pulse per repetition.
// - Internal analog modulation pulses at the modulation rate.
// - Internal keying pulses at the keying rate.
// - External modulation turns the aux pin into an input, no pulses.
// - Sweep or burst suppresses pulses and hides the sync settings.
module sp_sync_out
  import sp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ch1_period_tick,
  input  wire logic        ch1_mod_tick,
  input  wire sp_wave_t    ch1_wave,
  input  wire sp_mod_t     ch1_mod,
  input  wire logic        ch1_over_10m,
  input  wire logic        ch1_sweep_burst,
  input  wire logic        ch2_period_tick,
  input  wire logic        ch2_mod_tick,
  input  wire sp_wave_t    ch2_wave,
  input  wire sp_mod_t     ch2_mod,
  input  wire logic        ch2_over_10m,
  input  wire logic        ch2_sweep_burst,
  input  wire logic        aux_in,
  output logic             aux_out,
  output logic             aux_oe,
  output logic             ext_mod_in,
  output logic             sync_menu_show
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic        ctrl_en_q;
  logic        ctrl_en_d;
  logic        ctrl_src_q;
  logic        ctrl_src_d;
  logic        act_en_q;
  logic        act_en_d;
  logic        act_src_q;
  logic        act_src_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        aux_out_q;
  logic        aux_out_d;
  logic        aux_oe_q;
  logic        aux_oe_d;
  logic        aux_meta_q;
  logic        aux_sync_q;

  logic [1:0]  ch_tick;
  logic [1:0]  ch_allow;
  logic [1:0]  ch_ext;
  logic        sel_tick;
  logic        sel_allow;
  logic        sel_ext;
  logic        sel_hidden;
  logic        start;
  logic        abort;
  logic        pulse;
  logic        started;
  logic        pending;
  logic        setup;
  logic        access;
  logic        wr_ok;
  logic        addr_hit;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // ==========================================================================
  // Per-channel timing
  // ==========================================================================
  sp_chan_timing u_ch1 (
    .period_tick (ch1_period_tick),
    .mod_tick    (ch1_mod_tick),
    .wave        (ch1_wave),
    .modulation  (ch1_mod),
    .over_10m    (ch1_over_10m),
    .sweep_burst (ch1_sweep_burst),
    .tick        (ch_tick[0]),
    .allow       (ch_allow[0]),
    .ext_mod     (ch_ext[0])
  );

  sp_chan_timing u_ch2 (
    .period_tick (ch2_period_tick),
    .mod_tick    (ch2_mod_tick),
    .wave        (ch2_wave),
    .modulation  (ch2_mod),
    .over_10m    (ch2_over_10m),
    .sweep_burst (ch2_sweep_burst),
    .tick        (ch_tick[1]),
    .allow       (ch_allow[1]),
    .ext_mod     (ch_ext[1])
  );

  // ==========================================================================
  // Source selection and pulse start
  // ==========================================================================
  always_comb begin
    sel_tick   = act_src_q ? ch_tick[1] : ch_tick[0];
    sel_allow  = act_src_q ? ch_allow[1] : ch_allow[0];
    sel_ext    = act_src_q ? ch_ext[1] : ch_ext[0];
    // Menu hiding follows the channel software is looking at
    sel_hidden = ctrl_src_q ? ch2_sweep_burst : ch1_sweep_burst;
  end

  // ==========================================================================
  // Pulse trigger and abort
  // ==========================================================================
  always_comb begin
    start = act_en_q && sel_allow && sel_tick;
    // A mode that forbids pulses cuts off one already in flight
    abort = !act_en_q || !sel_allow;
  end

  sp_pulse_gen #(
    .WIDTH (PULSE_CYCLES)
  ) u_pulse (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (start),
    .abort   (abort),
    .pulse   (pulse),
    .started (started)
  );

  // ==========================================================================
  // Applying settings between pulses
  // ==========================================================================
  // Held off while a pulse is high, so software cuts a pulse short only when a setting applies in the cycle it starts
  assign pending = (act_en_q != ctrl_en_q) || (act_src_q != ctrl_src_q);

  always_comb begin
    act_en_d  = act_en_q;
    act_src_d = act_src_q;
    if (pending && !pulse) begin
      act_en_d  = ctrl_en_q;
      act_src_d = ctrl_src_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_en_q  <= CTRL_EN_RST;
      act_src_q <= CTRL_SRC_RST;
    end else begin
      act_en_q  <= act_en_d;
      act_src_q <= act_src_d;
    end
  end

  // ==========================================================================
  // Aux pin drive
  // ==========================================================================
  always_comb begin
    aux_oe_d  = !sel_ext;
    aux_out_d = pulse && act_en_q && !sel_ext;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_oe_q  <= 1'b1;
      aux_out_q <= 1'b0;
    end else begin
      aux_oe_q  <= aux_oe_d;
      aux_out_q <= aux_out_d;
    end
  end

  // ==========================================================================
  // Aux pin input
  // ==========================================================================
  // The pin is driven from outside the clock domain: two flops before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_meta_q <= 1'b0;
      aux_sync_q <= 1'b0;
    end else begin
      aux_meta_q <= aux_in;
      aux_sync_q <= aux_meta_q;
    end
  end

  assign aux_out        = aux_out_q;
  assign aux_oe         = aux_oe_q;
  // External modulating signal, only meaningful while the pin is an input
  assign ext_mod_in     = aux_sync_q && !aux_oe_q;
  assign sync_menu_show = !sel_hidden;

  // ==========================================================================
  // Read words
  // ==========================================================================
  // Built apart from the bus so the setup snapshot is a single mux
  always_comb begin
    ctrl_word                   = 32'h0000_0000;
    ctrl_word[CTRL_EN_BIT]      = ctrl_en_q;
    ctrl_word[CTRL_SRC_BIT]     = ctrl_src_q;
    status_word                 = 32'h0000_0000;
    status_word[STAT_EN_BIT]    = act_en_q;
    status_word[STAT_SRC_BIT]   = act_src_q;
    status_word[STAT_SUPP_BIT]  = !sel_allow;
    status_word[STAT_PULSE_BIT] = pulse;
    status_word[STAT_MENU_BIT]  = !sel_hidden;
    status_word[STAT_PEND_BIT]  = pending;
    status_word[STAT_EXT_BIT]   = sel_ext;
  end

  always_comb begin
    case (paddr)
      SP_CTRL_OFS:   rd_word = ctrl_word;
      SP_STATUS_OFS: rd_word = status_word;
      SP_COUNT_OFS:  rd_word = count_q;
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign addr_hit = (paddr == SP_CTRL_OFS) || (paddr == SP_STATUS_OFS) ||
                    (paddr == SP_COUNT_OFS);
  // Settings are hidden, and so locked, while sweep or burst runs
  assign wr_ok    = access && pwrite && pstrb[0] && !sel_hidden;

  always_comb begin
    ctrl_en_d  = ctrl_en_q;
    ctrl_src_d = ctrl_src_q;
    count_d    = count_q;
    prdata_d   = prdata_q;
    pslverr_d  = 1'b0;
    if (started && act_en_q) begin
      count_d = count_q + 32'h0000_0001;
    end
    if (setup) begin
      pslverr_d = !addr_hit;
      prdata_d  = 32'h0000_0000;
      if (!pwrite) begin
        prdata_d = rd_word;
      end
    end
    if (wr_ok && !pslverr_q) begin
      case (paddr)
        SP_CTRL_OFS: begin
          ctrl_en_d  = pwdata[CTRL_EN_BIT];
          ctrl_src_d = pwdata[CTRL_SRC_BIT];
        end
        // Any write clears; a pulse in the same cycle is dropped from the count
        SP_COUNT_OFS: count_d = 32'h0000_0000;
        default: begin
        end
      endcase
    end
    if (access) begin
      pslverr_d = pslverr_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en_q  <= CTRL_EN_RST;
      ctrl_src_q <= CTRL_SRC_RST;
      count_q    <= 32'h0000_0000;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
    end else begin
      ctrl_en_q  <= ctrl_en_d;
      ctrl_src_q <= ctrl_src_d;
      count_q    <= count_d;
      prdata_q   <= prdata_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // Every register answers from flops, so no wait state is ever needed
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = access && pslverr_q;

endmodule

// ---- core/sp_pkg.sv ----
// Purpose: Shared constants and types for the sync pulse output block
// Assumes: 125 MHz system clock, APB register access with 32-bit data
// Notes:   Register offsets are byte addresses of aligned words
package sp_pkg;

  // ==========================================================================
  // Clock and pulse timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned PULSE_WIDTH_NS = 100;
  // Nearest whole number of cycles to the fixed width: 12.5 becomes 13
  localparam int unsigned PULSE_CYCLES =
    (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int unsigned PULSE_CNT_W = 8;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] SP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SP_STATUS_OFS = 8'h04;
  localparam logic [7:0] SP_COUNT_OFS  = 8'h08;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_SRC_BIT = 1;

  localparam int unsigned STAT_EN_BIT      = 0;
  localparam int unsigned STAT_SRC_BIT     = 1;
  localparam int unsigned STAT_SUPP_BIT    = 2;
  localparam int unsigned STAT_PULSE_BIT   = 3;
  localparam int unsigned STAT_MENU_BIT    = 4;
  localparam int unsigned STAT_PEND_BIT    = 5;
  localparam int unsigned STAT_EXT_BIT     = 6;

  localparam logic       CTRL_EN_RST  = 1'b0;
  localparam logic       CTRL_SRC_RST = 1'b0;
  localparam logic [1:0] SRC_CH1      = 2'h0;

  // ==========================================================================
  // Channel modes
  // ==========================================================================
  typedef enum logic [1:0] {
    SP_WAVE_BASIC,
    SP_WAVE_ARB,
    SP_WAVE_NOISE,
    SP_WAVE_DC
  } sp_wave_t;

  typedef enum logic [1:0] {
    SP_MOD_NONE,
    SP_MOD_INT_ANALOG,
    SP_MOD_INT_KEYING,
    SP_MOD_EXTERNAL
  } sp_mod_t;

endpackage

// ---- core/sp_chan_timing.sv ----
// Purpose: Derive one channel's sync timing tick and its permission
// Assumes: All inputs come from logic on sys_clk
// Notes:   Instantiated once per output channel
`timescale 1ns/1ps
module sp_chan_timing
  import sp_pkg::*;
(
  input  wire logic     period_tick,
  input  wire logic     mod_tick,
  input  wire sp_wave_t wave,
  input  wire sp_mod_t  modulation,
  input  wire logic     over_10m,
  input  wire logic     sweep_burst,
  output logic          tick,
  output logic          allow,
  output logic          ext_mod
);

  // ==========================================================================
  // Tick source and suppression
  // ==========================================================================
  always_comb begin
    ext_mod = (modulation == SP_MOD_EXTERNAL);
    case (modulation)
      SP_MOD_INT_ANALOG: tick = mod_tick;
      SP_MOD_INT_KEYING: tick = mod_tick;
      default:           tick = period_tick;
    endcase
    allow = 1'b1;
    if (sweep_burst) begin
      allow = 1'b0;
    end else if (ext_mod) begin
      allow = 1'b0;
    end else if (wave == SP_WAVE_NOISE || wave == SP_WAVE_DC) begin
      // Noise or DC has no period to mark, even when modulated
      allow = 1'b0;
    end else if (modulation == SP_MOD_NONE) begin
      case (wave)
        SP_WAVE_BASIC: allow = !over_10m;
        default:       allow = 1'b1;
      endcase
    end
  end

endmodule

// ---- core/sp_pulse_gen.sv ----
// Purpose: Fixed-width pulse from a one-cycle start
// Assumes: Start arrives on sys_clk; width counted in clock cycles
// Notes:   Starts during a pulse are ignored; abort ends it at once
`timescale 1ns/1ps
module sp_pulse_gen
  import sp_pkg::*;
#(
  parameter int unsigned WIDTH = PULSE_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      pulse,
  output logic      started
);

  logic [PULSE_CNT_W-1:0] cnt_q;
  logic [PULSE_CNT_W-1:0] cnt_d;

  // ==========================================================================
  // Width counter
  // ==========================================================================
  always_comb begin
    cnt_d   = cnt_q;
    started = 1'b0;
    if (abort) begin
      cnt_d = '0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end else if (start) begin
      cnt_d   = PULSE_CNT_W'(WIDTH);
      started = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign pulse = (cnt_q != '0);

endmodule

// ---- tb/sp_sync_assertions.sv ----
// Purpose: Port checks for the sync pulse output
// Assumes: One sys_clk domain, synchronous reset
// Notes:   Source is hidden here, so mode checks load both channels
`timescale 1ns/1ps
module sp_sync_chk
  import sp_pkg::*;
(
  input wire logic     sys_clk,
  input wire logic     rst,
  input wire logic     psel,
  input wire logic     penable,
  input wire logic     pwrite,
  input wire logic     ch1_period_tick,
  input wire logic     ch1_mod_tick,
  input wire sp_wave_t ch1_wave,
  input wire sp_mod_t  ch1_mod,
  input wire logic     ch1_over_10m,
  input wire logic     ch1_sweep_burst,
  input wire logic     ch2_period_tick,
  input wire logic     ch2_mod_tick,
  input wire sp_wave_t ch2_wave,
  input wire sp_mod_t  ch2_mod,
  input wire logic     ch2_over_10m,
  input wire logic     ch2_sweep_burst,
  input wire logic     aux_in,
  input wire logic     aux_out,
  input wire logic     aux_oe,
  input wire logic     ext_mod_in,
  input wire logic     sync_menu_show
);
  // ==========================================================
  // Helpers
  // ==========================================================
  logic [7:0] hi_q, hi_d;
  logic       wr_q, wr_d;
  logic       tk, nd, hf, sb, ex;
  assign tk = ch1_period_tick | ch1_mod_tick | ch2_period_tick
            | ch2_mod_tick;
  // Noise and DC share the upper code bit
  assign nd = ch1_wave[1] & ch2_wave[1];
  assign hf = ch1_over_10m & ch2_over_10m & (ch1_wave == SP_WAVE_BASIC)
            & (ch2_wave == SP_WAVE_BASIC) & (ch1_mod == SP_MOD_NONE)
            & (ch2_mod == SP_MOD_NONE);
  assign sb = ch1_sweep_burst & ch2_sweep_burst;
  assign ex = (ch1_mod == SP_MOD_EXTERNAL) & (ch2_mod == SP_MOD_EXTERNAL);
  always_comb begin
    hi_d = aux_out ? hi_q + 8'h01 : 8'h00;
    wr_d = wr_q | (psel & penable & pwrite);
  end
  always_ff @(posedge sys_clk) begin
    hi_q <= rst ? 8'h00 : hi_d;
    wr_q <= rst ? 1'b0 : wr_d;
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Three cycles of a state give the abort time to land
  sequence s_hold(logic x);
    x [*3];
  endsequence
  AST_ENABLE: assert property (aux_out |-> wr_q)
    else $error("pulse before any enable write");
  AST_WIDTH: assert property (aux_out |-> hi_q < 8'h0D)
    else $error("pulse longer than fixed width");
  AST_START: assert property ($rose(aux_out) |-> $past(tk, 2))
    else $error("pulse without a period start");
  AST_FAST: assert property (s_hold(hf) |-> !aux_out)
    else $error("pulse above frequency limit");
  AST_NOISE: assert property (s_hold(nd) |-> !aux_out)
    else $error("pulse on noise or DC");
  AST_EXT: assert property (s_hold(ex) |-> !aux_oe && !aux_out)
    else $error("pin driven under external modulation");
  AST_EXT_IN: assert property (aux_oe |-> !ext_mod_in)
    else $error("modulation input seen while driving");
  // While released, the pin level reaches the output two flops later
  property p_ext_seen;
    !aux_oe |-> ext_mod_in == $past(aux_in, 2);
  endproperty
  AST_EXT_SEEN: assert property (p_ext_seen)
    else $error("modulation input does not follow the pin");
  AST_SWEEP: assert property (s_hold(sb) |-> !aux_out)
    else $error("pulse during sweep or burst");
  AST_MENU: assert property (sb |-> !sync_menu_show)
    else $error("menu shown during sweep or burst");
endmodule
bind sp_sync_out sp_sync_chk u_chk (.sys_clk, .rst, .psel, .penable,
  .pwrite, .ch1_period_tick, .ch1_mod_tick, .ch1_wave, .ch1_mod,
  .ch1_over_10m, .ch1_sweep_burst, .ch2_period_tick, .ch2_mod_tick,
  .ch2_wave, .ch2_mod, .ch2_over_10m, .ch2_sweep_burst, .aux_out,
  .aux_in, .aux_oe, .ext_mod_in, .sync_menu_show);

// ---- tb/sp_scope.sv ----
// Purpose: Test equipment on the aux pin: counts and times pulses
// Assumes: Samples on sys_clk
// Notes:   Feeds a toggling modulating signal while the pin is released
`timescale 1ns/1ps
module sp_scope (
  input  wire logic        sys_clk,
  input  wire logic        aux_out,
  input  wire logic        aux_oe,
  output logic             aux_in,
  output logic [15:0]      pulses,
  output logic [7:0]       width
);
  logic [7:0] run;
  initial begin
    aux_in = 1'b0;
    pulses = 16'h0000;
    width = 8'h00;
    run = 8'h00;
  end
  always @(posedge sys_clk) begin
    // Driven pin reads back the block; released pin toggles, never stale
    aux_in <= aux_oe ? aux_out : ~aux_in;
    if (aux_oe && aux_out) begin
      run <= run + 8'h01;
    end else if (run != 8'h00) begin
      pulses <= pulses + 16'h0001;
      width <= run;
      run <= 8'h00;
    end
  end
endmodule

// ---- tb/tb_sp_sync_out.sv ----
// Purpose: Self-checking bench for the sync pulse output
// Assumes: 125 MHz clock, APB master, both channels set to the same mode
// Notes:   Byte strobes tied to all ones
`timescale 1ns/1ps
`define CHK(a, e, m) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      num_errors++; \
      $display("BAD %0t %s", $time, m); \
    end \
  end
module tb_sp_sync_out;
  import sp_pkg::*;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, width;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        t1, m1, o1, s1, t2, m2, o2, s2, er;
  logic        aux_in, aux_out, aux_oe, ext_mod_in, menu;
  sp_wave_t    w1, w2;
  sp_mod_t     d1, d2;
  logic [15:0] pulses;
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  sp_sync_out DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ch1_period_tick(t1),
    .ch1_mod_tick(m1), .ch1_wave(w1), .ch1_mod(d1), .ch1_over_10m(o1),
    .ch1_sweep_burst(s1), .ch2_period_tick(t2), .ch2_mod_tick(m2),
    .ch2_wave(w2), .ch2_mod(d2), .ch2_over_10m(o2), .ch2_sweep_burst(s2),
    .aux_in, .aux_out, .aux_oe, .ext_mod_in, .sync_menu_show(menu));
  sp_scope u_scope (.sys_clk, .aux_out, .aux_oe, .aux_in, .pulses, .width);
  // ==========================================================
  // Bus and stimulus tasks
  // ==========================================================
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Held until an edge samples pready high; only the bench timeout
    // ends a wait that never finishes
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mode(sp_wave_t w, sp_mod_t d, logic o, logic s);
    @(posedge sys_clk);
    w1 <= w;
    w2 <= w;
    d1 <= d;
    d2 <= d;
    {o1, o2, s1, s2} <= {o, o, s, s};
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic tick(input logic c, input logic m);
    @(posedge sys_clk);
    {m2, t2, m1, t1} <= 4'h1 << {c, m};
    @(posedge sys_clk);
    {m2, t2, m1, t1} <= 4'h0;
  endtask
  task automatic pulse(input logic c, input logic m, input int n);
    logic [15:0] p0;
    p0 = pulses;
    tick(c, m);
    repeat (20) @(posedge sys_clk);
    `CHK(pulses - p0, 16'(n), "pulse count")
    if (n != 0) `CHK(width, 8'(PULSE_CYCLES), "pulse width")
  endtask
  task automatic quiet();
    pulse(1'b1, 1'b0, 0);
    pulse(1'b1, 1'b1, 0);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic s_reset();
    apb(1'b0, SP_CTRL_OFS, 32'h0);
    `CHK(rd[1:0], {CTRL_SRC_RST, CTRL_EN_RST}, "ctrl reset")
    apb(1'b0, SP_STATUS_OFS, 32'h0);
    `CHK(rd[STAT_MENU_BIT], 1'b1, "menu hidden")
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(er, 1'b1, "unmapped accepted")
    pulse(1'b0, 1'b0, 0);
  endtask
  task automatic s_source();
    apb(1'b1, SP_CTRL_OFS, 32'h1);
    pulse(1'b0, 1'b0, 1);
    pulse(1'b1, 1'b0, 0);
    apb(1'b1, SP_CTRL_OFS, 32'h3);
    pulse(1'b1, 1'b0, 1);
    pulse(1'b0, 1'b0, 0);
    apb(1'b0, SP_COUNT_OFS, 32'h0);
    `CHK(rd, 32'h2, "pulse tally")
  endtask
  task automatic s_modes();
    mode(SP_WAVE_ARB, SP_MOD_NONE, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1);
    mode(SP_WAVE_BASIC, SP_MOD_INT_ANALOG, 1'b0, 1'b0);
    pulse(1'b1, 1'b1, 1);
    pulse(1'b1, 1'b0, 0);
    mode(SP_WAVE_BASIC, SP_MOD_INT_KEYING, 1'b0, 1'b0);
    pulse(1'b1, 1'b1, 1);
    pulse(1'b1, 1'b0, 0);
  endtask
  task automatic s_forbid();
    logic v;
    mode(SP_WAVE_BASIC, SP_MOD_NONE, 1'b1, 1'b0);
    quiet();
    mode(SP_WAVE_NOISE, SP_MOD_NONE, 1'b0, 1'b0);
    quiet();
    mode(SP_WAVE_DC, SP_MOD_NONE, 1'b0, 1'b0);
    quiet();
    mode(SP_WAVE_NOISE, SP_MOD_INT_ANALOG, 1'b0, 1'b0);
    quiet();
    mode(SP_WAVE_BASIC, SP_MOD_EXTERNAL, 1'b0, 1'b0);
    quiet();
    `CHK(aux_oe, 1'b0, "pin still driven")
    v = ext_mod_in;
    @(posedge sys_clk);
    `CHK(ext_mod_in, !v, "modulation input stuck")
    mode(SP_WAVE_BASIC, SP_MOD_NONE, 1'b0, 1'b1);
    quiet();
    `CHK(menu, 1'b0, "menu shown")
    apb(1'b1, SP_CTRL_OFS, 32'h0);
    apb(1'b0, SP_CTRL_OFS, 32'h0);
    `CHK(rd[1:0], 2'h3, "hidden setting changed")
  endtask
  task automatic s_change();
    logic [15:0] p0;
    mode(SP_WAVE_BASIC, SP_MOD_NONE, 1'b0, 1'b0);
    p0 = pulses;
    tick(1'b1, 1'b0);
    apb(1'b1, SP_CTRL_OFS, 32'h0);
    apb(1'b0, SP_STATUS_OFS, 32'h0);
    `CHK(rd[STAT_EN_BIT], 1'b1, "enable dropped mid pulse")
    repeat (20) @(posedge sys_clk);
    `CHK(pulses - p0, 16'h0001, "pulse lost")
    `CHK(width, 8'(PULSE_CYCLES), "pulse cut")
    pulse(1'b1, 1'b0, 0);
  endtask
  task automatic test_done();
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Whole run needs about 600 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, t1, m1, o1, s1, t2, m2, o2, s2} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    w1 = SP_WAVE_BASIC;
    w2 = SP_WAVE_BASIC;
    d1 = SP_MOD_NONE;
    d2 = SP_MOD_NONE;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    s_reset();
    s_source();
    s_modes();
    s_forbid();
    s_change();
    test_done();
  end
endmodule
